// file: logic/sspo_pkg.sv
package sspo_pkg;
   // apb byte addresses
   localparam logic [7:0] ADDR_SEL      = 8'h00;
   localparam logic [7:0] ADDR_SPD_LVL  = 8'h04;
   localparam logic [7:0] ADDR_DIV_NUM  = 8'h08;
   localparam logic [7:0] ADDR_DIV_DEN  = 8'h0c;
   localparam logic [7:0] ADDR_REVERSE  = 8'h10;
   localparam logic [7:0] ADDR_IDX_INT  = 8'h14;
   localparam logic [7:0] ADDR_ENC_RES  = 8'h18;
   localparam logic [7:0] ADDR_STATE    = 8'h1c;
   localparam logic [7:0] ADDR_INT_STAT = 8'h20;
   localparam logic [7:0] ADDR_INT_MASK = 8'h24;
   // selector field positions and reset values
   localparam int         SEL_TRQ_LSB   = 0;
   localparam int         SEL_SPD_LSB   = 8;
   localparam logic [3:0] SEL_TRQ_RST   = 4'h0;
   localparam logic [3:0] SEL_SPD_RST   = 4'h1;
   localparam logic [15:0] SPD_LVL_RST  = 16'h0032;
   localparam logic [15:0] DIV_NUM_RST  = 16'h0001;
   localparam logic [15:0] DIV_DEN_RST  = 16'h0001;
   localparam logic [15:0] IDX_INT_RST  = 16'h0001;
   localparam logic [15:0] ENC_RES_RST  = 16'h2710;
   // reverse register bits
   localparam int         REV_B_INV     = 0;
   localparam int         REV_SRC_SCALE = 1;
   // selector codes
   localparam logic [3:0] SEL_TRQ_CLIP  = 4'h0;
   localparam logic [3:0] SEL_ZERO_SPD  = 4'h1;
   localparam logic [3:0] SEL_ANY_WARN  = 4'h2;
   localparam logic [3:0] SEL_REGEN     = 4'h3;
   localparam logic [3:0] SEL_OVERLOAD  = 4'h4;
   localparam logic [3:0] SEL_BATTERY   = 4'h5;
   localparam logic [3:0] SEL_FAN       = 4'h6;
   localparam logic [3:0] SEL_SCALE     = 4'h7;
   localparam logic [3:0] SEL_IN_SPEED  = 4'h8;
   // warning thresholds
   localparam logic [7:0]  REGEN_PCT    = 8'h23;
   localparam logic [7:0]  LOAD_PCT     = 8'h55;
   localparam logic [15:0] BATT_MV      = 16'h0c80;
   localparam logic [7:0]  SCALE_DEG    = 8'h41;
   // timing
   localparam longint CLK_HZ       = 100_000_000;
   localparam longint QUAD_MAX_HZ  = 4_000_000;
   localparam int     QUAD_GAP_CYC = int'((CLK_HZ + QUAD_MAX_HZ - 1) / QUAD_MAX_HZ);
   localparam longint FAN_STALL_MS = 1000;
   localparam longint FAN_STALL_CYC = FAN_STALL_MS * (CLK_HZ / 1000);
   localparam int     INT_W        = 5;
   typedef enum logic [2:0] {
      Z_IDLE = 3'b001,
      Z_WAIT = 3'b010,
      Z_HIGH = 3'b100
   } sspo_zst_t;
endpackage : sspo_pkg

// file: logic/sspo_pulse_div.sv
module sspo_pulse_div (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        step_in,
   input  wire logic        dir_in,
   input  wire logic [15:0] num_in,
   input  wire logic [15:0] den_in,
   output logic             step_out,
   output logic             dir_out,
   output logic             ovr_out
);
   logic [16:0] acc_r;
   logic signed [7:0] pend_r;
   logic [7:0]  gap_r;
   logic [16:0] acc_sum;
   logic        hit;
   logic        emit;
   logic signed [7:0] pend_in;
   logic signed [7:0] pend_nxt;
   logic        sat;

   // ratio above one gives at most one count per input step
   assign acc_sum  = acc_r + {1'b0, num_in};
   assign hit      = step_in && (den_in != 16'h0000) && (acc_sum >= {1'b0, den_in});
   assign emit     = (pend_r != 8'sh00) && (gap_r == 8'h00);
   assign sat      = hit && (dir_in ? (pend_r == -8'sd128) : (pend_r == 8'sd127));
   assign pend_in  = (hit && !sat) ? (dir_in ? -8'sd1 : 8'sd1) : 8'sh00;
   assign pend_nxt = pend_r + pend_in - (emit ? ((pend_r < 0) ? -8'sd1 : 8'sd1) : 8'sh00);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         acc_r    <= 17'h00000;
         pend_r   <= 8'sh00;
         gap_r    <= 8'h00;
         step_out <= 1'b0;
         dir_out  <= 1'b0;
         ovr_out  <= 1'b0;
      end else begin
         if (step_in) begin
            acc_r <= hit ? acc_sum - {1'b0, den_in} : acc_sum;
         end
         pend_r   <= pend_nxt;
         // spacing keeps quadrature edges at or under the rate ceiling
         gap_r    <= emit ? 8'(sspo_pkg::QUAD_GAP_CYC - 1) :
                     (gap_r != 8'h00) ? gap_r - 8'h01 : 8'h00;
         step_out <= emit;
         dir_out  <= emit ? (pend_r < 0) : dir_out;
         ovr_out  <= sat;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   property p_gap;
      step_out |=> !step_out [*8];
   endproperty
   a_gap: assert property (p_gap) else $error("quadrature steps too close");
endmodule : sspo_pulse_div

// file: logic/sspo_top.sv
// Overview of operation
// - sel 0: servo on and torque clipped
// - sel 1: speed below detect level
// - two pins, own selectors, defaults 0/1
// - sel 2: OR of five warnings
// - sel 3: regeneration above 35 percent
// - sel 4: load above 85 percent
// - sel 5: battery under 3.2 volts
// - sel 6: fan stalled over one second
// - sel 7: scale hot/weak, full-closed only
// - sel 8: in-speed, velocity/torque only
// - differential A/B/Z from divided source
// - rate scaled by numerator over denominator, ratios up to one
// - reverse picks B logic and source
// - quadrature edges at most 4 Mpps
// - encoder Z aligned when multiple of four
// - scale Z suppressed until zero crossed
// - scale Z every N A-pulses, aligned
module sspo_top #(
   parameter longint FAN_STALL_CYC = sspo_pkg::FAN_STALL_CYC
) (
   input  wire logic        CLK_IN,
   input  wire logic        SYS_RST_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [7:0]  PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic [31:0]      PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   input  wire logic        SERVO_ON_IN,
   input  wire logic        TORQUE_CLIP_IN,
   input  wire logic [15:0] MOTOR_SPEED_IN,
   input  wire logic [15:0] SPEED_CMD_IN,
   input  wire logic [7:0]  REGEN_PCT_IN,
   input  wire logic [7:0]  LOAD_PCT_IN,
   input  wire logic [15:0] BATT_MV_IN,
   input  wire logic        FAN_STALL_IN,
   input  wire logic [7:0]  SCALE_TEMP_IN,
   input  wire logic        SCALE_WEAK_IN,
   input  wire logic        FULL_CLOSED_IN,
   input  wire logic        VEL_TRQ_MODE_IN,
   input  wire logic        ENC_STEP_IN,
   input  wire logic        ENC_DIR_IN,
   input  wire logic        ENC_INDEX_IN,
   input  wire logic        SCALE_STEP_IN,
   input  wire logic        SCALE_DIR_IN,
   input  wire logic        SCALE_ZERO_IN,
   output logic             TORQUE_CLIP_OUT,
   output logic             LOW_SPEED_OUT,
   output logic             PHASE_A_OUT,
   output logic             PHASE_A_N_OUT,
   output logic             PHASE_B_OUT,
   output logic             PHASE_B_N_OUT,
   output logic             PHASE_Z_OUT,
   output logic             PHASE_Z_N_OUT,
   output logic             INDEX_OPEN_COLLECTOR_OUT,
   output logic             IRQ_OUT
);
   localparam int W = sspo_pkg::INT_W;

   function automatic logic [15:0] abs16(input logic [15:0] v);
      abs16 = v[15] ? 16'(-v) : v;
   endfunction : abs16

   function automatic logic pick(input logic [3:0] sel, input logic [8:0] c);
      pick = (sel <= sspo_pkg::SEL_IN_SPEED) ? c[sel] : 1'b0;
   endfunction : pick

   // registers
   logic [3:0]  torque_flag_selector_r;
   logic [3:0]  speed_flag_selector_r;
   logic [15:0] speed_detect_level_r;
   logic [15:0] pulse_div_numerator_r;
   logic [15:0] pulse_div_denominator_r;
   logic [1:0]  pulse_logic_reverse_r;
   logic [15:0] scale_index_interval_r;
   logic [15:0] enc_res_r;
   logic [W-1:0] int_stat_r;
   logic [W-1:0] int_mask_r;
   logic [31:0] fan_cnt_r;
   logic        fan_warn_r;
   logic        warn_r;
   logic [1:0]  quad_r;
   logic        scale_armed_r;
   logic [15:0] a_cnt_r;
   sspo_pkg::sspo_zst_t zst_r;
   sspo_pkg::sspo_zst_t zst_nxt;

   // apb decode
   wire         acc_ph   = PSEL_IN && PENABLE_IN && PREADY_OUT;
   wire         wr_en    = acc_ph && PWRITE_IN;
   wire         hit_sel  = PADDR_IN == sspo_pkg::ADDR_SEL;
   wire         hit_lvl  = PADDR_IN == sspo_pkg::ADDR_SPD_LVL;
   wire         hit_num  = PADDR_IN == sspo_pkg::ADDR_DIV_NUM;
   wire         hit_den  = PADDR_IN == sspo_pkg::ADDR_DIV_DEN;
   wire         hit_rev  = PADDR_IN == sspo_pkg::ADDR_REVERSE;
   wire         hit_idx  = PADDR_IN == sspo_pkg::ADDR_IDX_INT;
   wire         hit_res  = PADDR_IN == sspo_pkg::ADDR_ENC_RES;
   wire         hit_st   = PADDR_IN == sspo_pkg::ADDR_STATE;
   wire         hit_is   = PADDR_IN == sspo_pkg::ADDR_INT_STAT;
   wire         hit_im   = PADDR_IN == sspo_pkg::ADDR_INT_MASK;
   wire         mapped   = hit_sel | hit_lvl | hit_num | hit_den | hit_rev | hit_idx |
                           hit_res | hit_st | hit_is | hit_im;
   wire [31:0]  state_word = {24'h000000, scale_armed_r, PHASE_Z_OUT, PHASE_B_OUT,
                              PHASE_A_OUT, warn_r, LOW_SPEED_OUT, TORQUE_CLIP_OUT, 1'b0};
   wire [31:0]  rd_data  =
      hit_sel ? {20'h00000, speed_flag_selector_r, 4'h0, torque_flag_selector_r} :
      hit_lvl ? {16'h0000, speed_detect_level_r} :
      hit_num ? {16'h0000, pulse_div_numerator_r} :
      hit_den ? {16'h0000, pulse_div_denominator_r} :
      hit_rev ? {30'h00000000, pulse_logic_reverse_r} :
      hit_idx ? {16'h0000, scale_index_interval_r} :
      hit_res ? {16'h0000, enc_res_r} :
      hit_st  ? state_word :
      hit_is  ? {27'h0000000, int_stat_r} :
      hit_im  ? {27'h0000000, int_mask_r} : 32'h00000000;

   // drive conditions
   wire [15:0]  spd_abs   = abs16(MOTOR_SPEED_IN);
   wire [15:0]  spd_err   = abs16(16'(MOTOR_SPEED_IN - SPEED_CMD_IN));
   wire         c_clip    = SERVO_ON_IN && TORQUE_CLIP_IN;
   wire         c_zero    = spd_abs < speed_detect_level_r;
   wire         c_regen   = REGEN_PCT_IN > sspo_pkg::REGEN_PCT;
   wire         c_load    = LOAD_PCT_IN > sspo_pkg::LOAD_PCT;
   wire         c_batt    = BATT_MV_IN < sspo_pkg::BATT_MV;
   wire         c_scale   = FULL_CLOSED_IN &&
                            (SCALE_TEMP_IN > sspo_pkg::SCALE_DEG || SCALE_WEAK_IN);
   wire         c_inspd   = VEL_TRQ_MODE_IN && (spd_err <= speed_detect_level_r);
   wire         c_any     = c_regen | c_load | c_batt | fan_warn_r | c_scale;
   wire [8:0]   conds     = {c_inspd, c_scale, fan_warn_r, c_batt, c_load, c_regen,
                             c_any, c_zero, c_clip};
   wire         trq_nxt   = pick(torque_flag_selector_r, conds);
   wire         spd_nxt   = pick(speed_flag_selector_r, conds);

   // pulse source and division
   wire         src_scale = pulse_logic_reverse_r[sspo_pkg::REV_SRC_SCALE];
   wire         src_step  = src_scale ? SCALE_STEP_IN : ENC_STEP_IN;
   wire         src_dir   = src_scale ? SCALE_DIR_IN : ENC_DIR_IN;
   wire         q_step;
   wire         q_dir;
   wire         q_ovr;

   sspo_pulse_div u_div (
      .clk_in   (CLK_IN),
      .rst_in   (SYS_RST_IN),
      .step_in  (src_step),
      .dir_in   (src_dir),
      .num_in   (pulse_div_numerator_r),
      .den_in   (pulse_div_denominator_r),
      .step_out (q_step),
      .dir_out  (q_dir),
      .ovr_out  (q_ovr)
   );

   wire [1:0]   quad_nxt  = q_step ? (q_dir ? quad_r - 2'h1 : quad_r + 2'h1) : quad_r;
   wire         a_nxt     = quad_nxt[1];
   wire         b_nxt     = (quad_nxt[1] ^ quad_nxt[0]) ^
                            pulse_logic_reverse_r[sspo_pkg::REV_B_INV];
   wire         a_rise    = a_nxt && !PHASE_A_OUT;
   wire         a_fall    = !a_nxt && PHASE_A_OUT;
   // alignment needs resolution*num/den divisible by four
   wire [31:0]  res_prod  = enc_res_r * pulse_div_numerator_r;
   wire [17:0]  den4      = {pulse_div_denominator_r, 2'b00};
   wire         z_align   = (den4 != 18'h00000) && ((res_prod % 32'(den4)) == 32'h0);
   wire [15:0]  idx_last  = (scale_index_interval_r == 16'h0000) ? 16'h0000 :
                            scale_index_interval_r - 16'h0001;
   wire         idx_due   = a_cnt_r >= idx_last;

   always_comb begin
      zst_nxt = zst_r;
      unique case (zst_r)
         sspo_pkg::Z_IDLE: begin
            if (src_scale) begin
               if (scale_armed_r && a_rise && idx_due) begin
                  zst_nxt = sspo_pkg::Z_HIGH;
               end
            end else if (ENC_INDEX_IN) begin
               zst_nxt = z_align ? sspo_pkg::Z_WAIT : sspo_pkg::Z_HIGH;
            end
         end
         sspo_pkg::Z_WAIT: begin
            if (src_scale) begin
               zst_nxt = sspo_pkg::Z_IDLE;
            end else if (a_rise) begin
               zst_nxt = sspo_pkg::Z_HIGH;
            end
         end
         sspo_pkg::Z_HIGH: begin
            // unaligned index lasts one source step
            if (!src_scale && !z_align ? ENC_STEP_IN : a_fall) begin
               zst_nxt = sspo_pkg::Z_IDLE;
            end
         end
         default: zst_nxt = sspo_pkg::Z_IDLE;
      endcase
   end

   wire [W-1:0] events    = {q_ovr, SCALE_ZERO_IN, c_any && !warn_r,
                             spd_nxt && !LOW_SPEED_OUT, trq_nxt && !TORQUE_CLIP_OUT};
   wire [W-1:0] w1c       = (wr_en && hit_is) ? PWDATA_IN[W-1:0] : '0;

   // apb slave: one access cycle, error on unmapped address
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         PREADY_OUT  <= 1'b0;
         PRDATA_OUT  <= 32'h00000000;
         PSLVERR_OUT <= 1'b0;
      end else begin
         PREADY_OUT  <= PSEL_IN && !PENABLE_IN;
         PRDATA_OUT  <= (PSEL_IN && !PENABLE_IN && !PWRITE_IN) ? rd_data : PRDATA_OUT;
         PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !mapped;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         torque_flag_selector_r  <= sspo_pkg::SEL_TRQ_RST;
         speed_flag_selector_r   <= sspo_pkg::SEL_SPD_RST;
         speed_detect_level_r    <= sspo_pkg::SPD_LVL_RST;
         pulse_div_numerator_r   <= sspo_pkg::DIV_NUM_RST;
         pulse_div_denominator_r <= sspo_pkg::DIV_DEN_RST;
         pulse_logic_reverse_r   <= 2'b00;
         scale_index_interval_r  <= sspo_pkg::IDX_INT_RST;
         enc_res_r               <= sspo_pkg::ENC_RES_RST;
         int_mask_r              <= '0;
      end else if (wr_en) begin
         if (hit_sel) begin
            torque_flag_selector_r <= PWDATA_IN[sspo_pkg::SEL_TRQ_LSB +: 4];
            speed_flag_selector_r  <= PWDATA_IN[sspo_pkg::SEL_SPD_LSB +: 4];
         end
         if (hit_lvl) speed_detect_level_r    <= PWDATA_IN[15:0];
         if (hit_num) pulse_div_numerator_r   <= PWDATA_IN[15:0];
         if (hit_den) pulse_div_denominator_r <= PWDATA_IN[15:0];
         if (hit_rev) pulse_logic_reverse_r   <= PWDATA_IN[1:0];
         if (hit_idx) scale_index_interval_r  <= PWDATA_IN[15:0];
         if (hit_res) enc_res_r               <= PWDATA_IN[15:0];
         if (hit_im)  int_mask_r              <= PWDATA_IN[W-1:0];
      end
   end

   // status outputs and interrupt
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         TORQUE_CLIP_OUT <= 1'b0;
         LOW_SPEED_OUT   <= 1'b0;
         warn_r          <= 1'b0;
         fan_cnt_r       <= 32'h00000000;
         fan_warn_r      <= 1'b0;
         int_stat_r      <= '0;
         IRQ_OUT         <= 1'b0;
      end else begin
         TORQUE_CLIP_OUT <= trq_nxt;
         LOW_SPEED_OUT   <= spd_nxt;
         warn_r          <= c_any;
         fan_cnt_r       <= !FAN_STALL_IN ? 32'h00000000 :
                            (fan_cnt_r < 32'(FAN_STALL_CYC)) ? fan_cnt_r + 32'h1 : fan_cnt_r;
         fan_warn_r      <= FAN_STALL_IN && (fan_cnt_r >= 32'(FAN_STALL_CYC));
         // set wins over a same-cycle clear
         int_stat_r      <= (int_stat_r & ~w1c) | events;
         IRQ_OUT         <= |(((int_stat_r & ~w1c) | events) & int_mask_r);
      end
   end

   // pulse outputs
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         quad_r                   <= 2'b00;
         PHASE_A_OUT              <= 1'b0;
         PHASE_A_N_OUT            <= 1'b1;
         PHASE_B_OUT              <= 1'b0;
         PHASE_B_N_OUT            <= 1'b1;
         PHASE_Z_OUT              <= 1'b0;
         PHASE_Z_N_OUT            <= 1'b1;
         INDEX_OPEN_COLLECTOR_OUT <= 1'b0;
         scale_armed_r            <= 1'b0;
         a_cnt_r                  <= 16'h0000;
         zst_r                    <= sspo_pkg::Z_IDLE;
      end else begin
         quad_r                   <= quad_nxt;
         PHASE_A_OUT              <= a_nxt;
         PHASE_A_N_OUT            <= !a_nxt;
         PHASE_B_OUT              <= b_nxt;
         PHASE_B_N_OUT            <= !b_nxt;
         PHASE_Z_OUT              <= zst_nxt == sspo_pkg::Z_HIGH;
         PHASE_Z_N_OUT            <= zst_nxt != sspo_pkg::Z_HIGH;
         INDEX_OPEN_COLLECTOR_OUT <= zst_nxt == sspo_pkg::Z_HIGH;
         // arming survives source changes; only reset clears it
         scale_armed_r            <= scale_armed_r || SCALE_ZERO_IN;
         if (!scale_armed_r || !src_scale) begin
            a_cnt_r <= 16'h0000;
         end else if (a_rise) begin
            a_cnt_r <= idx_due ? 16'h0000 : a_cnt_r + 16'h0001;
         end
         zst_r                    <= zst_nxt;
      end
   end

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   property p_clip;
      (torque_flag_selector_r == 4'h0) && SERVO_ON_IN && TORQUE_CLIP_IN |=> TORQUE_CLIP_OUT;
   endproperty
   a_clip: assert property (p_clip) else $error("clip not shown");

   property p_zero;
      (speed_flag_selector_r == 4'h1) && (spd_abs < speed_detect_level_r) |=> LOW_SPEED_OUT;
   endproperty
   a_zero: assert property (p_zero) else $error("low speed not shown");

   property p_warn;
      (torque_flag_selector_r == 4'h2) && !c_any |=> !TORQUE_CLIP_OUT;
   endproperty
   a_warn: assert property (p_warn) else $error("warning without cause");

   property p_regen;
      (speed_flag_selector_r == 4'h3) && (REGEN_PCT_IN > 8'h23) |=> LOW_SPEED_OUT;
   endproperty
   a_regen: assert property (p_regen) else $error("regen warning missed");

   property p_fan;
      !FAN_STALL_IN |=> !fan_warn_r ##1 !fan_warn_r;
   endproperty
   a_fan: assert property (p_fan) else $error("fan warning early");

   property p_inspd;
      (torque_flag_selector_r == 4'h8) && !VEL_TRQ_MODE_IN |=> !TORQUE_CLIP_OUT;
   endproperty
   a_inspd: assert property (p_inspd) else $error("in-speed outside mode");

   property p_noz;
      src_scale && !scale_armed_r && $stable(src_scale) |=> !PHASE_Z_OUT;
   endproperty
   a_noz: assert property (p_noz) else $error("scale index before zero");

   property p_ready;
      PSEL_IN && !PENABLE_IN |=> PREADY_OUT ##1 !PREADY_OUT;
   endproperty
   a_ready: assert property (p_ready) else $error("apb answer timing"); 
endmodule : sspo_top

// file: verif/sspo_host_model.sv
module sspo_host_model (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic a_in,
   input  wire logic a_n_in,
   input  wire logic b_in,
   input  wire logic b_n_in,
   input  wire logic z_in,
   input  wire logic z_n_in,
   input  wire logic oc_in,
   output int        cnt_out,
   output int        zc_out,
   output int        gap_out,
   output int        bad_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]      q_r;
   logic            z_r;
   logic            seen_r;
   int              gap_r;
   wire logic [1:0] dq = {a_in, a_in ^ b_in} - q_r;
   always @(posedge clk_in) begin
      if (rst_in) begin
         q_r     <= 2'h0;
         z_r     <= 1'b0;
         seen_r  <= 1'b0;
         cnt_out <= 0;
         zc_out  <= 0;
         gap_r   <= 1000;
         gap_out <= 1000;
         bad_out <= 0;
      end else begin
         q_r   <= {a_in, a_in ^ b_in};
         z_r   <= z_in;
         gap_r <= (dq == 2'h0) ? gap_r + 1 : 1;
         if (dq != 2'h0 && gap_r < gap_out) gap_out <= gap_r;
         if (dq == 2'h1) cnt_out <= cnt_out + 1;
         if (dq == 2'h3) cnt_out <= cnt_out - 1;
         if (z_in && !z_r) zc_out <= zc_out + 1;
         // seen_r records that an index was seen; bad_out does not use it
         if (z_in && !z_r) seen_r <= 1'b1;
         // a skipped quadrature state or a broken pair is an error
         if (dq == 2'h2 || a_in === a_n_in || b_in === b_n_in || z_in === z_n_in ||
             oc_in !== z_in)
            bad_out <= bad_out + 1;
      end
   end
endmodule : sspo_host_model

// file: verif/sspo_top_tb.sv
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module sspo_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FAN_CYC = 50;
   localparam int MIN_GAP = 25; // 100 MHz clock over 4 Mpps
   logic CLK_IN, SYS_RST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, PSLVERR_OUT, err;
   logic SERVO_ON_IN, TORQUE_CLIP_IN, FAN_STALL_IN, SCALE_WEAK_IN, FULL_CLOSED_IN;
   logic VEL_TRQ_MODE_IN, ENC_STEP_IN, ENC_DIR_IN, ENC_INDEX_IN, SCALE_STEP_IN, SCALE_DIR_IN;
   logic SCALE_ZERO_IN, TORQUE_CLIP_OUT, LOW_SPEED_OUT, IRQ_OUT, PA, PAN, PB, PBN, PZ, PZN, PC;
   logic [7:0]  PADDR_IN, REGEN_PCT_IN, LOAD_PCT_IN, SCALE_TEMP_IN;
   logic [15:0] MOTOR_SPEED_IN, SPEED_CMD_IN, BATT_MV_IN;
   logic [31:0] PWDATA_IN, PRDATA_OUT, lfsr_r, w_exp, w_act, exp_q[$], act_q[$];
   int          num_errors = 0, cmp_count = 0, cyc = 0, h_cnt, h_z, h_gap, h_bad;
   sspo_top #(.FAN_STALL_CYC(FAN_CYC)) u_dut (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
      .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
      .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
      .PSLVERR_OUT(PSLVERR_OUT), .SERVO_ON_IN(SERVO_ON_IN), .TORQUE_CLIP_IN(TORQUE_CLIP_IN),
      .MOTOR_SPEED_IN(MOTOR_SPEED_IN), .SPEED_CMD_IN(SPEED_CMD_IN), .REGEN_PCT_IN(REGEN_PCT_IN),
      .LOAD_PCT_IN(LOAD_PCT_IN), .BATT_MV_IN(BATT_MV_IN), .FAN_STALL_IN(FAN_STALL_IN),
      .SCALE_TEMP_IN(SCALE_TEMP_IN), .SCALE_WEAK_IN(SCALE_WEAK_IN),
      .FULL_CLOSED_IN(FULL_CLOSED_IN), .VEL_TRQ_MODE_IN(VEL_TRQ_MODE_IN),
      .ENC_STEP_IN(ENC_STEP_IN), .ENC_DIR_IN(ENC_DIR_IN), .ENC_INDEX_IN(ENC_INDEX_IN),
      .SCALE_STEP_IN(SCALE_STEP_IN), .SCALE_DIR_IN(SCALE_DIR_IN), .SCALE_ZERO_IN(SCALE_ZERO_IN),
      .TORQUE_CLIP_OUT(TORQUE_CLIP_OUT), .LOW_SPEED_OUT(LOW_SPEED_OUT), .PHASE_A_OUT(PA),
      .PHASE_A_N_OUT(PAN), .PHASE_B_OUT(PB), .PHASE_B_N_OUT(PBN), .PHASE_Z_OUT(PZ),
      .PHASE_Z_N_OUT(PZN), .INDEX_OPEN_COLLECTOR_OUT(PC), .IRQ_OUT(IRQ_OUT));
   sspo_host_model u_host (.clk_in(CLK_IN), .rst_in(SYS_RST_IN), .a_in(PA), .a_n_in(PAN),
      .b_in(PB), .b_n_in(PBN), .z_in(PZ), .z_n_in(PZN), .oc_in(PC), .cnt_out(h_cnt), .zc_out(h_z),
      .gap_out(h_gap), .bad_out(h_bad));
   initial begin
      CLK_IN = 1'b0;
      forever #5 CLK_IN = ~CLK_IN;
   end
   // watcher: oldest note against each result
   always @(posedge CLK_IN) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         tally_and_finish();
      end
      if (PSEL_IN && PENABLE_IN && PREADY_OUT === 1'b1 && !PWRITE_IN) begin
         w_exp = exp_q.pop_front();
         `CHK(PRDATA_OUT, w_exp)
      end else if (act_q.size() > 0) begin
         w_exp = exp_q.pop_front();
         w_act = act_q.pop_front();
         `CHK(w_act, w_exp)
      end
   end
   function automatic logic [31:0] lfsr_next();
      lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
      return lfsr_r;
   endfunction : lfsr_next
   task automatic chk(input logic [31:0] e, input logic [31:0] a);
      exp_q.push_back(e);
      act_q.push_back(a);
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge CLK_IN);
      PSEL_IN    <= 1'b1;
      PENABLE_IN <= 1'b0;
      PWRITE_IN  <= w;
      PADDR_IN   <= a;
      PWDATA_IN  <= d;
      @(posedge CLK_IN);
      PENABLE_IN <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK_IN);
         n++;
      end while (PREADY_OUT !== 1'b1 && n < 20);
      if (PREADY_OUT !== 1'b1) num_errors++;
      err = PSLVERR_OUT;
      PSEL_IN    <= 1'b0;
      PENABLE_IN <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd
   // quiet plant: clipped but servo off, hot scale outside full-closed
   task automatic base();
      {SERVO_ON_IN, TORQUE_CLIP_IN, FAN_STALL_IN, SCALE_WEAK_IN} <= 4'h4;
      {FULL_CLOSED_IN, VEL_TRQ_MODE_IN} <= 2'h0;
      {MOTOR_SPEED_IN, SPEED_CMD_IN, BATT_MV_IN} <= {16'h03e8, 16'h03e8, 16'h0e10};
      {REGEN_PCT_IN, LOAD_PCT_IN, SCALE_TEMP_IN} <= {8'h00, 8'h00, 8'h42};
   endtask : base
   task automatic cond(input int c, input logic on);
      base();
      @(posedge CLK_IN);
      case (c)
         0: SERVO_ON_IN <= on;
         1: MOTOR_SPEED_IN <= on ? 16'(lfsr_next() % 50) : 16'h0032;
         2, 3: REGEN_PCT_IN <= on ? 8'h24 : 8'h23;
         4: LOAD_PCT_IN <= on ? 8'h56 : 8'h55;
         5: BATT_MV_IN <= on ? 16'h0c7f : 16'h0c80;
         6: FAN_STALL_IN <= on;
         7: FULL_CLOSED_IN <= on;
         default: VEL_TRQ_MODE_IN <= on;
      endcase
      repeat (FAN_CYC + 20) @(posedge CLK_IN);
   endtask : cond
   task automatic steps(input logic scl, input int n, input int gap, input logic dir);
      repeat (n) begin
         @(posedge CLK_IN);
         {ENC_STEP_IN, SCALE_STEP_IN, ENC_DIR_IN, SCALE_DIR_IN} <= {!scl, scl, dir, dir};
         @(posedge CLK_IN);
         {ENC_STEP_IN, SCALE_STEP_IN} <= 2'h0;
         repeat (gap) @(posedge CLK_IN);
      end
      // drain: pending counts leave one per 25 cycles
      repeat (n * 30 + 40) @(posedge CLK_IN);
   endtask : steps
   task automatic blip(input logic scl);
      @(posedge CLK_IN);
      {ENC_INDEX_IN, SCALE_ZERO_IN} <= {!scl, scl};
      @(posedge CLK_IN);
      {ENC_INDEX_IN, SCALE_ZERO_IN} <= 2'h0;
   endtask : blip
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   initial begin
      int n, c0, z0;
      lfsr_r = 32'h094b808f;
      base();
      {SYS_RST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PADDR_IN, PWDATA_IN} <= 44'h800_0000_0000;
      {ENC_STEP_IN, SCALE_STEP_IN, ENC_DIR_IN, SCALE_DIR_IN, ENC_INDEX_IN, SCALE_ZERO_IN} <= 6'h0;
      repeat (5) @(posedge CLK_IN);
      SYS_RST_IN <= 1'b0;
      rd(sspo_pkg::ADDR_SEL, 32'h100);
      rd(8'h40, 32'h0);
      chk(32'h1, {31'h0, err});
      for (int c = 0; c < 9; c++) begin
         apb(1'b1, sspo_pkg::ADDR_SEL, {20'h0, c[3:0], 4'h0, c[3:0]});
         for (int on = 1; on >= 0; on--) begin
            cond(c, on[0]);
            chk({31'h0, on[0]}, {31'h0, TORQUE_CLIP_OUT});
            chk({31'h0, on[0]}, {31'h0, LOW_SPEED_OUT});
         end
      end
      $display("status selector test done");
      apb(1'b1, sspo_pkg::ADDR_SEL, 32'h0f00);
      cond(0, 1'b0);
      apb(1'b1, sspo_pkg::ADDR_INT_STAT, 32'h1f);
      apb(1'b1, sspo_pkg::ADDR_INT_MASK, 32'h1);
      cond(0, 1'b1);
      chk(32'h1, {31'h0, IRQ_OUT});
      rd(sspo_pkg::ADDR_INT_STAT, 32'h1);
      apb(1'b1, sspo_pkg::ADDR_INT_STAT, 32'h1);
      rd(sspo_pkg::ADDR_INT_STAT, 32'h0);
      chk(32'h0, {31'h0, IRQ_OUT});
      apb(1'b1, sspo_pkg::ADDR_INT_MASK, 32'h0);
      cond(0, 1'b0);
      cond(0, 1'b1);
      chk(32'h0, {31'h0, IRQ_OUT});
      rd(sspo_pkg::ADDR_INT_STAT, 32'h1);
      $display("interrupt test done");
      c0 = h_cnt;
      n = 8 + int'(lfsr_next() % 8);
      steps(1'b0, n, 0, 1'b0);
      chk(32'(n), 32'(h_cnt - c0));
      chk(32'h1, {31'h0, h_gap >= MIN_GAP});
      apb(1'b1, sspo_pkg::ADDR_REVERSE, 32'h1);
      repeat (3) @(posedge CLK_IN);
      c0 = h_cnt;
      steps(1'b0, 8, 0, 1'b0);
      chk(32'(-8), 32'(h_cnt - c0));
      apb(1'b1, sspo_pkg::ADDR_REVERSE, 32'h0);
      apb(1'b1, sspo_pkg::ADDR_DIV_DEN, 32'h3);
      c0 = h_cnt;
      steps(1'b0, 24, 30, 1'b1);
      chk(32'(-8), 32'(h_cnt - c0));
      z0 = h_z;
      blip(1'b0);
      steps(1'b0, 1, 0, 1'b0);
      apb(1'b1, sspo_pkg::ADDR_DIV_DEN, 32'h1);
      blip(1'b0);
      steps(1'b0, 8, 0, 1'b0);
      chk(32'h2, 32'(h_z - z0));
      $display("encoder pulse test done");
      apb(1'b1, sspo_pkg::ADDR_REVERSE, 32'h2);
      apb(1'b1, sspo_pkg::ADDR_IDX_INT, 32'h2);
      {c0, z0} = {h_cnt, h_z};
      steps(1'b1, 8, 0, 1'b0);
      chk(32'h0, 32'(h_z - z0));
      chk(32'h8, 32'(h_cnt - c0));
      blip(1'b1);
      z0 = h_z;
      steps(1'b1, 16, 0, 1'b0);
      chk(32'h2, 32'(h_z - z0));
      chk(32'h0, 32'(h_bad));
      repeat (3) @(posedge CLK_IN);
      $display("scale pulse test done");
      tally_and_finish();
   end
endmodule : sspo_top_tb
